// file: verilog/icca_pkg.sv
package icca_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] ICCA_ADDR_CTRL = 8'h00;
  localparam logic [7:0] ICCA_ADDR_KSEL = 8'h04;
  localparam logic [7:0] ICCA_ADDR_KEN = 8'h08;
  localparam logic [7:0] ICCA_ADDR_STAT = 8'h0c;
  localparam logic [7:0] ICCA_ADDR_LCRC = 8'h10;
  localparam logic [7:0] ICCA_ADDR_FRMS = 8'h14;

  // field positions
  localparam int ICCA_CTRL_MASTER_BIT = 0;
  localparam int ICCA_KSEL_BIT = 0;
  localparam int ICCA_KEN_BIT = 0;
  localparam int ICCA_STAT_MASTER_BIT = 0;
  localparam int ICCA_STAT_CRCEN_BIT = 1;
  localparam int ICCA_STAT_IDXEN_BIT = 2;
  localparam int ICCA_STAT_SEQ_BIT = 3;
  localparam int ICCA_STAT_STATE_LSB = 4;

  // reset values
  localparam logic ICCA_MASTER_RST = 1'b0;
  localparam logic ICCA_KSEL_RST = 1'b0;
  localparam logic [1:0] ICCA_EN_RST = 2'h0;

  // chunk kinds as seen through trailer_kind_select
  localparam logic payload_checksum_kind = 1'b0;
  localparam logic param_set_index_kind = 1'b1;

  // checksum definition
  localparam logic [15:0] ICCA_CRC_POLY = 16'h1021;
  localparam logic [15:0] ICCA_CRC_INIT = 16'h0000;
  localparam int ICCA_CRC_BYTES = 2;

  // default width of the index chunk
  localparam int ICCA_IDX_BYTES = 4;
  localparam int ICCA_IDX_W = 8;

  typedef enum logic [1:0] {
    icca_s_pay = 2'b00,
    icca_s_idx = 2'b01,
    icca_s_crc = 2'b10
  } icca_state_t;

endpackage

// file: verilog/icca_crc16_byte.sv
`timescale 1ns/1ps
module icca_crc16_byte
  import icca_pkg::*;
(
  input wire logic [15:0] crc_in,
  input wire logic [7:0] data_in,
  output logic [15:0] crc_out
);

  logic [15:0] chain [0:8];

  assign chain[0] = crc_in;

  // one shift stage per data bit, msb of the byte first, no reflection
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      logic fb;
      assign fb = chain[i][15] ^ data_in[7 - i];
      assign chain[i + 1] = {chain[i][14:0], 1'b0} ^ (fb ? ICCA_CRC_POLY : 16'h0000);
    end
  endgenerate

  assign crc_out = chain[8];

endmodule

// file: verilog/icca_appender.sv
`timescale 1ns/1ps
// Functional notes
// - with the checksum chunk enabled every image gets a trailer holding an xmodem checksum.
// - the checksum covers all payload bytes and every earlier chunk but not its own bytes.
// - the checksum chunk is always the last thing sent after the image and other chunks.
// - no chunk kind can be enabled while the master trailer enable is off.
// - clearing the master trailer enable clears every chunk enable so later images get none.
// - a kind is enabled by selecting it and then writing its enable true, and acts on later images.
// - with the index chunk enabled each frame carries the parameter set index used to acquire it.
// - the index chunk can only be enabled while the sequencer is enabled as well as the master.
// - an enabled index chunk goes on every image started while the sequencer is enabled, not only on some.
module icca_appender
  import icca_pkg::*;
#(
  parameter int IDX_W = ICCA_IDX_W,
  parameter int IDX_BYTES = ICCA_IDX_BYTES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sequencer_enabled,
  input wire logic [IDX_W-1:0] param_set_index_value,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  output logic in_ready,
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last,
  input wire logic out_ready
);

  localparam int SH_W = IDX_BYTES * 8;
  localparam int CNT_W = $clog2(IDX_BYTES + 1) + 1;
  localparam logic [CNT_W-1:0] CNT_IDX_LAST = CNT_W'(IDX_BYTES - 1);
  localparam logic [CNT_W-1:0] CNT_CRC_LAST = CNT_W'(ICCA_CRC_BYTES - 1);

  // control registers
  logic trailer_master_enable_q;
  logic trailer_kind_select_q;
  logic [1:0] trailer_kind_enable_q;

  // stream state
  icca_state_t state_q;
  icca_state_t state_d;
  logic sof_q;
  logic fr_crc_q;
  logic fr_idx_q;
  logic [SH_W-1:0] idx_sh_q;
  logic [CNT_W-1:0] cnt_q;
  logic [15:0] crc_q;
  logic [15:0] crc_next;
  logic [15:0] last_crc_q;
  logic [31:0] frames_q;
  logic out_valid_q;
  logic [7:0] out_data_q;
  logic out_last_q;

  // combinational helpers
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic ready_int;
  logic emit;
  logic take;
  logic cur_crc;
  logic cur_idx;
  logic [7:0] byte_mux;
  logic last_mux;
  logic [31:0] rd_mux;

  // apb decode, zero wait state slave
  assign wr_en = ce && psel && penable && pwrite;
  assign rd_setup = ce && psel && !penable && !pwrite;
  assign pready = 1'b1;

  always_comb begin
    if (paddr == ICCA_ADDR_CTRL) begin
      addr_ok = 1'b1;
    end else if (paddr == ICCA_ADDR_KSEL) begin
      addr_ok = 1'b1;
    end else if (paddr == ICCA_ADDR_KEN) begin
      addr_ok = 1'b1;
    end else if (paddr == ICCA_ADDR_STAT) begin
      addr_ok = 1'b1;
    end else if (paddr == ICCA_ADDR_LCRC) begin
      addr_ok = 1'b1;
    end else if (paddr == ICCA_ADDR_FRMS) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  assign pslverr = psel && penable && !addr_ok;

  // master enable; dropping it wipes all kind enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trailer_master_enable_q <= ICCA_MASTER_RST;
    end else if (wr_en && paddr == ICCA_ADDR_CTRL) begin
      trailer_master_enable_q <= pwdata[ICCA_CTRL_MASTER_BIT];
    end
  end

  // kind selector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trailer_kind_select_q <= ICCA_KSEL_RST;
    end else if (wr_en && paddr == ICCA_ADDR_KSEL) begin
      trailer_kind_select_q <= pwdata[ICCA_KSEL_BIT];
    end
  end

  // per kind enables, written through the selector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trailer_kind_enable_q <= ICCA_EN_RST;
    end else if (wr_en && paddr == ICCA_ADDR_CTRL) begin
      if (!pwdata[ICCA_CTRL_MASTER_BIT]) begin
        trailer_kind_enable_q <= ICCA_EN_RST;
      end
    end else if (wr_en && paddr == ICCA_ADDR_KEN) begin
      if (!pwdata[ICCA_KEN_BIT]) begin
        trailer_kind_enable_q[trailer_kind_select_q] <= 1'b0;
      end else if (trailer_master_enable_q) begin
        if (trailer_kind_select_q == payload_checksum_kind) begin
          trailer_kind_enable_q[payload_checksum_kind] <= 1'b1;
        end else if (sequencer_enabled) begin
          trailer_kind_enable_q[param_set_index_kind] <= 1'b1;
        end
      end
    end
  end

  // read data captured in the setup phase
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == ICCA_ADDR_CTRL) begin
      rd_mux[ICCA_CTRL_MASTER_BIT] = trailer_master_enable_q;
    end else if (paddr == ICCA_ADDR_KSEL) begin
      rd_mux[ICCA_KSEL_BIT] = trailer_kind_select_q;
    end else if (paddr == ICCA_ADDR_KEN) begin
      rd_mux[ICCA_KEN_BIT] = trailer_kind_enable_q[trailer_kind_select_q];
    end else if (paddr == ICCA_ADDR_STAT) begin
      rd_mux[ICCA_STAT_MASTER_BIT] = trailer_master_enable_q;
      rd_mux[ICCA_STAT_CRCEN_BIT] = trailer_kind_enable_q[payload_checksum_kind];
      rd_mux[ICCA_STAT_IDXEN_BIT] = trailer_kind_enable_q[param_set_index_kind];
      rd_mux[ICCA_STAT_SEQ_BIT] = sequencer_enabled;
      rd_mux[ICCA_STAT_STATE_LSB +: 2] = state_q;
    end else if (paddr == ICCA_ADDR_LCRC) begin
      rd_mux[15:0] = last_crc_q;
    end else if (paddr == ICCA_ADDR_FRMS) begin
      rd_mux = frames_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  // enables seen by the frame: live on its first byte, frozen after that
  assign cur_crc = sof_q ?
                   (trailer_master_enable_q && trailer_kind_enable_q[payload_checksum_kind]) :
                   fr_crc_q;
  assign cur_idx = sof_q ? (trailer_master_enable_q && sequencer_enabled &&
                            trailer_kind_enable_q[param_set_index_kind]) : fr_idx_q;

  // output register accepts a new byte when empty or drained
  assign ready_int = !out_valid_q || out_ready;
  assign emit = (state_q == icca_s_pay) ? in_valid : 1'b1;
  assign take = ce && ready_int && emit;
  assign in_ready = ce && ready_int && (state_q == icca_s_pay);

  // byte source and end of frame marking
  always_comb begin
    byte_mux = in_data;
    last_mux = 1'b0;
    state_d = state_q;
    case (state_q)
      icca_s_pay: begin
        byte_mux = in_data;
        last_mux = in_last && !cur_idx && !cur_crc;
        if (in_last) begin
          if (cur_idx) begin
            state_d = icca_s_idx;
          end else if (cur_crc) begin
            state_d = icca_s_crc;
          end
        end
      end
      icca_s_idx: begin
        byte_mux = idx_sh_q[7:0];
        last_mux = (cnt_q == CNT_IDX_LAST) && !fr_crc_q;
        if (cnt_q == CNT_IDX_LAST) begin
          state_d = fr_crc_q ? icca_s_crc : icca_s_pay;
        end
      end
      icca_s_crc: begin
        byte_mux = (cnt_q == '0) ? crc_q[15:8] : crc_q[7:0];
        last_mux = (cnt_q == CNT_CRC_LAST);
        if (cnt_q == CNT_CRC_LAST) begin
          state_d = icca_s_pay;
        end
      end
      default: begin
        state_d = icca_s_pay;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= icca_s_pay;
    end else if (take) begin
      state_q <= state_d;
    end
  end

  // chunk byte counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (take) begin
      cnt_q <= (state_d != state_q) ? '0 : cnt_q + CNT_W'(1);
    end
  end

  // frame start marker and per frame latch of enables and index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sof_q <= 1'b1;
      fr_crc_q <= 1'b0;
      fr_idx_q <= 1'b0;
      idx_sh_q <= '0;
    end else if (take) begin
      if (state_q == icca_s_pay && sof_q) begin
        fr_crc_q <= cur_crc;
        fr_idx_q <= cur_idx;
        idx_sh_q <= SH_W'(param_set_index_value);
      end else if (state_q == icca_s_idx) begin
        idx_sh_q <= idx_sh_q >> 8; // low byte first
      end
      sof_q <= last_mux;
    end
  end

  icca_crc16_byte u_crc (
    .crc_in(crc_q),
    .data_in(byte_mux),
    .crc_out(crc_next)
  );

  // running checksum over payload and index bytes, restarted per frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_q <= ICCA_CRC_INIT;
    end else if (take) begin
      if (last_mux) begin
        crc_q <= ICCA_CRC_INIT;
      end else if (state_q != icca_s_crc) begin
        crc_q <= crc_next;
      end
    end
  end

  // last checksum sent and frame count, visible to software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_crc_q <= 16'h0000;
      frames_q <= 32'h0000_0000;
    end else if (take) begin
      if (state_q == icca_s_crc && cnt_q == '0) begin
        last_crc_q <= crc_q;
      end
      if (last_mux) begin
        frames_q <= frames_q + 32'h0000_0001;
      end
    end
  end

  // registered output stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid_q <= 1'b0;
      out_data_q <= 8'h00;
      out_last_q <= 1'b0;
    end else if (ce && ready_int) begin
      out_valid_q <= emit;
      if (emit) begin
        out_data_q <= byte_mux;
        out_last_q <= last_mux;
      end
    end
  end

  assign out_valid = out_valid_q && ce; // a frozen stage offers nothing, so no byte is lost
  assign out_data = out_data_q;
  assign out_last = out_last_q;

endmodule

// file: tb/icca_appender_assertions.sv
`timescale 1ns/1ps
module icca_appender_assertions
  import icca_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic out_ready
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  // decode of the six register words
  assign mapped = paddr inside {ICCA_ADDR_CTRL, ICCA_ADDR_KSEL, ICCA_ADDR_KEN,
                                ICCA_ADDR_STAT, ICCA_ADDR_LCRC, ICCA_ADDR_FRMS};
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_take;
    in_valid && in_ready;
  endsequence
  property p_ready;
    s_acc |-> pready;
  endproperty
  property p_err;
    s_acc ##0 !mapped |-> pslverr;
  endproperty
  property p_ok;
    s_acc ##0 mapped |-> !pslverr;
  endproperty
  property p_rd0;
    psel && penable && !pwrite && !mapped && $past(ce) |-> prdata == 32'h0;
  endproperty
  property p_stat;
    psel && penable && !pwrite && paddr == ICCA_ADDR_STAT && $past(ce) |->
      prdata[0] || !(prdata[1] || prdata[2]);
  endproperty
  property p_lat;
    s_take |=> out_data == $past(in_data) && (out_valid || !ce);
  endproperty
  property p_hold;
    out_valid && !out_ready |=> $stable(out_data) && $stable(out_last) && (out_valid || !ce);
  endproperty
  property p_frz;
    !ce |-> !out_valid;
  endproperty
  property p_end;
    ce && out_valid && out_ready && out_last |=> !out_valid || $past(in_valid && in_ready);
  endproperty
  property p_ce;
    !ce |-> !in_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("access phase without ready");
  a_err: assert property (p_err) else $error("unmapped access not flagged");
  a_ok: assert property (p_ok) else $error("mapped access flagged");
  a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
  a_stat: assert property (p_stat) else $error("kind enabled with master off");
  a_lat: assert property (p_lat) else $error("payload byte not forwarded");
  a_hold: assert property (p_hold) else $error("output changed while stalled");
  a_end: assert property (p_end) else $error("output after frame end");
  a_ce: assert property (p_ce) else $error("input taken while frozen");
  a_frz: assert property (p_frz) else $error("output offered while frozen");
endmodule

bind icca_appender icca_appender_assertions i_chk (.pclk, .presetn, .ce, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .in_valid, .in_data, .in_ready, .out_valid,
  .out_data, .out_last, .out_ready);

// file: tb/icca_host_sink.sv
`timescale 1ns/1ps
module icca_host_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  output logic out_ready,
  output logic intact,
  output int n_frames
);
  logic [7:0] cur[$];
  logic [7:0] frame[$];
  logic [15:0] crc;
  logic ph;
  // host takes bytes, stalling every other cycle when slow, and rechecks the trailer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ready <= 1'b0;
      ph <= 1'b0;
      n_frames <= 0;
      intact <= 1'b0;
      cur = {};
    end else begin
      ph <= ~ph;
      out_ready <= !slow || ph;
      if (out_valid && out_ready) begin
        cur.push_back(out_data);
        if (out_last) begin
          frame = cur;
          cur = {};
          crc = 16'h0000;
          for (int i = 0; i < frame.size() - 2; i++) begin
            crc = crc ^ {frame[i], 8'h00};
            repeat (8) crc = crc[15] ? ((crc << 1) ^ 16'h1021) : (crc << 1);
          end
          intact <= crc === {frame[frame.size() - 2], frame[frame.size() - 1]};
          n_frames <= n_frames + 1;
        end
      end
    end
  end
endmodule

// file: tb/tb_icca_appender.sv
`timescale 1ns/1ps
`define chk_eq(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
  $display("mismatch at %0t: got %h want %h", $time, (a), (e)); end end
module tb_icca_appender
  import icca_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic slow = 1'b0, seq_en = 1'b0, in_valid = 1'b0, in_last = 1'b0;
  logic [7:0] paddr = 8'h00, in_data = 8'h00, idx = 8'h00, out_data;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, in_ready, out_valid, out_last, out_ready, intact, err;
  int fails = 0, n_compared = 0, n_frames;
  logic [7:0] exp[$];

  // clock of 4 ns
  always #2 pclk = ~pclk;

  icca_appender i_icca_appender (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sequencer_enabled(seq_en),
    .param_set_index_value(idx), .in_valid, .in_data, .in_last, .in_ready, .out_valid,
    .out_data, .out_last, .out_ready);
  icca_host_sink i_host (.pclk, .presetn, .slow, .out_valid, .out_data, .out_last,
    .out_ready, .intact, .n_frames);

  task automatic complete_run();
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one apb transfer, entered and left just after a rising edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    `chk_eq(rd, e)
  endtask

  // payload bytes base, base+1, ... with in_last on the final one when lst
  task automatic send(input int n, input logic [7:0] base, input logic lst);
    for (int i = 0; i < n; i++) begin
      in_valid <= 1'b1;
      in_data <= base + 8'(i);
      in_last <= lst && (i == n - 1);
      exp.push_back(base + 8'(i));
      @(posedge pclk);
      while (in_ready !== 1'b1) @(posedge pclk);
    end
    in_valid <= 1'b0;
    in_last <= 1'b0;
  endtask

  task automatic check_frame(input int k, input int trail, input logic crc_on);
    repeat (300) if (n_frames < k) @(posedge pclk);
    `chk_eq(n_frames >= k, 1'b1)
    `chk_eq(i_host.frame.size(), exp.size() + trail)
    foreach (exp[i]) `chk_eq(i_host.frame[i], exp[i])
    if (crc_on) `chk_eq(intact, 1'b1)
    exp = {};
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    complete_run();
  end

  // register checks, then frames with each chunk set
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(ICCA_ADDR_STAT, 32'h0);
    chk(ICCA_ADDR_FRMS, 32'h0);
    chk(8'h18, 32'h0);
    `chk_eq(err, 1'b1)
    apb(ICCA_ADDR_KEN, 1'b1, 32'h1);
    chk(ICCA_ADDR_STAT, 32'h0);
    apb(ICCA_ADDR_CTRL, 1'b1, 32'h1);
    apb(ICCA_ADDR_KSEL, 1'b1, 32'h1);
    apb(ICCA_ADDR_KEN, 1'b1, 32'h1);
    chk(ICCA_ADDR_STAT, 32'h1);
    apb(ICCA_ADDR_KSEL, 1'b1, 32'h0);
    apb(ICCA_ADDR_KEN, 1'b1, 32'h1);
    chk(ICCA_ADDR_STAT, 32'h3);
    slow <= 1'b1;
    send(2, 8'h10, 1'b0);
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    ce <= 1'b1;
    send(1, 8'h12, 1'b1);
    check_frame(1, 2, 1'b1);
    seq_en <= 1'b1;
    apb(ICCA_ADDR_KSEL, 1'b1, 32'h1);
    apb(ICCA_ADDR_KEN, 1'b1, 32'h1);
    chk(ICCA_ADDR_STAT, 32'hf);
    slow <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      idx <= 8'ha5 + 8'(k * 3);
      send(1, 8'(k), 1'b1);
      exp.push_back(8'ha5 + 8'(k * 3));
      repeat (3) exp.push_back(8'h00);
      check_frame(2 + k, 2, 1'b1);
    end
    chk(ICCA_ADDR_FRMS, 32'h3);
    chk(ICCA_ADDR_LCRC, {16'h0000, i_host.crc});
    apb(ICCA_ADDR_CTRL, 1'b1, 32'h0);
    chk(ICCA_ADDR_STAT, 32'h8);
    send(2, 8'h20, 1'b1);
    check_frame(4, 0, 1'b0);
    complete_run();
  end
endmodule
